// ### ugfm_defines.svh
// Constants for the general-purpose pin function selector
`ifndef UGFM_DEFINES_SVH
`define UGFM_DEFINES_SVH

// Pin count and selector width
`define UGFM_NUM_PINS      8
`define UGFM_SEL_W         4

// Function selector codes
`define UGFM_FN_TRISTATE   4'h0
`define UGFM_FN_DRIVE1     4'h1
`define UGFM_FN_DRIVE0     4'h2
`define UGFM_FN_POWER_N    4'h3
`define UGFM_FN_TX_ACTIVITY_LED_N_N    4'h4
`define UGFM_FN_RX_ACTIVITY_LED_N_N    4'h5
`define UGFM_FN_ANYLED_N   4'h6
`define UGFM_FN_SLEEP_N    4'h7
`define UGFM_FN_CHG_BIT0   4'h8
`define UGFM_FN_CHG_BIT1   4'h9
`define UGFM_FN_VBUS_SENSE 4'hA

// Default charger code table
`define UGFM_CHG_UNCONF    2'h0
`define UGFM_CHG_SDP       2'h1
`define UGFM_CHG_CDP_DCP   2'h2
`define UGFM_CHG_SUSPEND   2'h3
`define UGFM_CHG_MAP_RESET 8'hE4

`endif

// ### ugfm_pkg.sv
// Types for the general-purpose pin function selector
package ugfm_pkg;
	// Charger state used to index the code table
	typedef enum logic [1:0] {
		UGFM_CHG_ST_UNCONF  = 2'h0,
		UGFM_CHG_ST_SDP     = 2'h1,
		UGFM_CHG_ST_CDP_DCP = 2'h2,
		UGFM_CHG_ST_SUSPEND = 2'h3
	} ugfm_chg_state_e;

	// Pull-up control state
	typedef enum logic [1:0] {
		UGFM_PU_OFF = 2'b01,
		UGFM_PU_ON  = 2'b10
	} ugfm_pu_state_e;
endpackage

// ### ugfm_sync2.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module ugfm_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // ugfm_sync2

// ### ugfm_pin_cell.sv
// One pin: function decode to output value and enable
`timescale 1ns/1ps
`include "ugfm_defines.svh"
module ugfm_pin_cell (
	// Selected function
	input  wire logic [3:0] sel_in,
	// Function sources
	input  wire logic       power_n_in,
	input  wire logic       tx_activity_led_n_n_in,
	input  wire logic       rx_activity_led_n_n_in,
	input  wire logic       anyled_n_in,
	input  wire logic       sleep_n_in,
	input  wire logic [1:0] chg_code_in,
	// Pin drive
	output logic            pin_d_out,
	output logic            pin_oe_d_out
);
	// Value mux; unknown codes fall back to floating
	always_comb begin
		pin_d_out    = 1'b0;
		pin_oe_d_out = 1'b1;
		case (sel_in)
			`UGFM_FN_DRIVE1:   pin_d_out = 1'b1;
			`UGFM_FN_DRIVE0:   pin_d_out = 1'b0;
			`UGFM_FN_POWER_N:  pin_d_out = power_n_in;
			`UGFM_FN_TX_ACTIVITY_LED_N_N:  pin_d_out = tx_activity_led_n_n_in;
			`UGFM_FN_RX_ACTIVITY_LED_N_N:  pin_d_out = rx_activity_led_n_n_in;
			`UGFM_FN_ANYLED_N: pin_d_out = anyled_n_in;
			`UGFM_FN_SLEEP_N:  pin_d_out = sleep_n_in;
			`UGFM_FN_CHG_BIT0: pin_d_out = chg_code_in[0];
			`UGFM_FN_CHG_BIT1: pin_d_out = chg_code_in[1];
			default:           pin_oe_d_out = 1'b0;
		endcase
	end
endmodule // ugfm_pin_cell

// ### ugfm_gpio_mux.sv
// Pin function selector for the bridge general-purpose pins
`timescale 1ns/1ps
`include "ugfm_defines.svh"
module ugfm_gpio_mux (
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// Configuration loaded at startup
	input  wire logic        cfg_load_in,
	input  wire logic [31:0] cfg_pin_sel_in,
	input  wire logic [7:0]  cfg_chg_map_in,
	input  wire logic        cfg_chg_detect_en_in,
	// USB device state, same clock
	input  wire logic        usb_configured_in,
	input  wire logic        usb_suspended_in,
	input  wire logic        usb_tx_active_in,
	input  wire logic        usb_rx_active_in,
	// Charger detection result, same clock
	input  wire logic        chg_port_valid_in,
	input  wire logic        chg_port_is_cdp_dcp_in,
	// General-purpose pins
	input  wire logic [7:0]  gpio_pin_in,
	output logic      [7:0]  gpio_pin_out,
	output logic      [7:0]  gpio_pin_oe_out,
	// Status and pull-up
	output logic             vbus_sense_out,
	output logic             vbus_for_chg_det_out,
	output logic             usb_dplus_pullup_en_out
);
	////////////////////////////////////////////////////////////////////////
	// Configuration storage
	logic [31:0] pin_sel_q;
	logic [7:0]  chg_map_q;
	logic        chg_det_en_q;

	// Held after load; defaults leave every pin floating
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_sel_q    <= 32'h0000_0000;
			chg_map_q    <= `UGFM_CHG_MAP_RESET;
			chg_det_en_q <= 1'b0;
		end else if (cfg_load_in) begin
			pin_sel_q    <= cfg_pin_sel_in;
			chg_map_q    <= cfg_chg_map_in;
			chg_det_en_q <= cfg_chg_detect_en_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin input synchroniser
	logic [7:0] gpio_sync;

	ugfm_sync2 #(.W(8)) u_pin_sync (
		.clk_in   (ref_clk_in),
		.rst_in   (rst_in),
		.async_in (gpio_pin_in),
		.sync_out (gpio_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Function sources, all active low where noted
	wire power_n  = ~usb_configured_in | usb_suspended_in;
	wire tx_activity_led_n_n  = ~usb_tx_active_in;
	wire rx_activity_led_n_n  = ~usb_rx_active_in;
	wire anyled_n = ~(usb_tx_active_in | usb_rx_active_in);
	wire sleep_n  = ~usb_suspended_in;

	// Charger state; suspend outranks port type
	ugfm_pkg::ugfm_chg_state_e chg_state;
	assign chg_state = usb_suspended_in ? ugfm_pkg::UGFM_CHG_ST_SUSPEND :
		!chg_port_valid_in ? ugfm_pkg::UGFM_CHG_ST_UNCONF :
		chg_port_is_cdp_dcp_in ? ugfm_pkg::UGFM_CHG_ST_CDP_DCP : ugfm_pkg::UGFM_CHG_ST_SDP;

	// Table lookup, two bits per state
	wire [1:0] chg_code = chg_map_q[{chg_state, 1'b0} +: 2];

	////////////////////////////////////////////////////////////////////////
	// Per-pin decode
	logic [7:0] pin_d;
	logic [7:0] pin_oe_d;
	logic [7:0] sense_sel;

	genvar gi;
	generate
		for (gi = 0; gi < `UGFM_NUM_PINS; gi++) begin : g_pin
			ugfm_pin_cell u_cell (
				.sel_in       (pin_sel_q[gi*4 +: 4]),
				.power_n_in   (power_n),
				.tx_activity_led_n_n_in   (tx_activity_led_n_n),
				.rx_activity_led_n_n_in   (rx_activity_led_n_n),
				.anyled_n_in  (anyled_n),
				.sleep_n_in   (sleep_n),
				.chg_code_in  (chg_code),
				.pin_d_out    (pin_d[gi]),
				.pin_oe_d_out (pin_oe_d[gi])
			);
			assign sense_sel[gi] = (pin_sel_q[gi*4 +: 4] == `UGFM_FN_VBUS_SENSE);
		end
	endgenerate

	// Any sense pin that reads high reports VBUS
	wire vbus_seen = |(sense_sel & gpio_sync);

	////////////////////////////////////////////////////////////////////////
	// Registered outputs; reset floats all pins and drops the pull-up
	ugfm_pkg::ugfm_pu_state_e pu_q;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			gpio_pin_out         <= 8'h00;
			gpio_pin_oe_out      <= 8'h00;
			vbus_sense_out       <= 1'b0;
			vbus_for_chg_det_out <= 1'b0;
			pu_q                 <= ugfm_pkg::UGFM_PU_OFF;
		end else begin
			gpio_pin_out         <= pin_d;
			gpio_pin_oe_out      <= pin_oe_d;
			vbus_sense_out       <= vbus_seen;
			vbus_for_chg_det_out <= vbus_seen & chg_det_en_q;
			pu_q                 <= ugfm_pkg::UGFM_PU_ON;
		end
	end

	// Pull-up enable registered one edge behind the state flop
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			usb_dplus_pullup_en_out <= 1'b0;
		end else begin
			usb_dplus_pullup_en_out <= (pu_q == ugfm_pkg::UGFM_PU_ON);
		end
	end
endmodule // ugfm_gpio_mux

// ### ugfm_gpio_mux_chk.sv
// Checker: pin 0 function timing, reset float and pull-up
`timescale 1ns/1ps
module ugfm_gpio_mux_chk (
	// Clock and reset
	input wire logic        ref_clk_in,
	input wire logic        rst_in,
	// Configuration and USB state
	input wire logic        cfg_load_in,
	input wire logic [31:0] cfg_pin_sel_in,
	input wire logic        usb_configured_in,
	input wire logic        usb_suspended_in,
	input wire logic        usb_tx_active_in,
	input wire logic        usb_rx_active_in,
	// Outputs
	input wire logic [7:0]  gpio_pin_out,
	input wire logic [7:0]  gpio_pin_oe_out,
	input wire logic        usb_dplus_pullup_en_out
);
	logic [3:0] sel_q;
	////////////////////////////////////////
	// Shadow of pin 0 selection as loaded
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			sel_q <= 4'h0;
		else if (cfg_load_in)
			sel_q <= cfg_pin_sel_in[3:0];
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// Pull-up off one more edge, then on
	sequence s_pu_late;
		!usb_dplus_pullup_en_out ##1 usb_dplus_pullup_en_out;
	endsequence
	a_power_gate: assert property (sel_q == 4'h3 |=>
		gpio_pin_out[0] == (!$past(usb_configured_in) || $past(usb_suspended_in))) else $error("power pin");
	a_tx_led: assert property (sel_q == 4'h4 |=> gpio_pin_out[0] == !$past(usb_tx_active_in)) else $error("tx led");
	a_rx_led: assert property (sel_q == 4'h5 |=> gpio_pin_out[0] == !$past(usb_rx_active_in)) else $error("rx led");
	a_any_led: assert property (sel_q == 4'h6 |=>
		gpio_pin_out[0] == !($past(usb_tx_active_in) || $past(usb_rx_active_in))) else $error("any led");
	a_sleep_ind: assert property (sel_q == 4'h7 |=> gpio_pin_out[0] == !$past(usb_suspended_in)) else $error("sleep");
	a_static_drive: assert property (sel_q inside {4'h1, 4'h2} |=>
		gpio_pin_oe_out[0] && gpio_pin_out[0] == $past(sel_q[0])) else $error("static drive");
	a_float_pin: assert property (!(sel_q inside {[4'h1:4'h9]}) |=> !gpio_pin_oe_out[0]) else $error("float");
	a_reset_float: assert property (disable iff (1'b0) rst_in |-> !gpio_pin_oe_out && !usb_dplus_pullup_en_out)
		else $error("reset drive");
	a_pullup_delay: assert property ($fell(rst_in) |=> s_pu_late) else $error("pull-up");
endmodule // ugfm_gpio_mux_chk
bind ugfm_gpio_mux ugfm_gpio_mux_chk ugfm_gpio_mux_chk_i (.*);

// ### ugfm_board.sv
// Board model: pin levels, VBUS divider and power switch
`timescale 1ns/1ps
module ugfm_board (
	// Pin drive and VBUS
	input  wire logic [7:0] pin_d_in,
	input  wire logic [7:0] pin_oe_in,
	input  wire logic       vbus_in,
	// Levels and switch
	output logic      [7:0] pin_lvl_out,
	output logic            pwr_on_out
);
	////////////////////////////////////////
	// Undriven pins sit on the divider, never a stale drive
	assign pin_lvl_out = (pin_d_in & pin_oe_in) | (~pin_oe_in & {8{vbus_in}});
	// Supply gated by a low power pin
	assign pwr_on_out = !pin_lvl_out[1];
endmodule // ugfm_board

// ### ugfm_gpio_mux_tb.sv
// Self-checking bench for the pin function selector
`timescale 1ns/1ps
module ugfm_gpio_mux_tb;
	logic        ref_clk_in = '0, rst_in = '0, cfg_load_in = '0, cfg_chg_detect_en_in = '0, vbus = '0;
	logic        usb_configured_in = '0, usb_suspended_in = '0, usb_tx_active_in = '0, usb_rx_active_in = '0;
	logic        chg_port_valid_in = '0, chg_port_is_cdp_dcp_in = '0, ha, pa, pu;
	logic        vbus_sense_out, vbus_for_chg_det_out, usb_dplus_pullup_en_out;
	logic [31:0] cfg_pin_sel_in = '0, sel_q;
	logic [7:0]  cfg_chg_map_in = 8'he4, gpio_pin_in, gpio_pin_out, gpio_pin_oe_out, map_q, eo, ed;
	int          n_mismatch = 0, checked = 0, cyc = 0, seed = 32'h4caf_7742;
	ugfm_gpio_mux ugfm_gpio_mux_i (.*);
	ugfm_board ugfm_board_i (.pin_d_in(gpio_pin_out), .pin_oe_in(gpio_pin_oe_out), .vbus_in(vbus),
		.pin_lvl_out(gpio_pin_in), .pwr_on_out());
	initial forever #2.5 ref_clk_in = ~ref_clk_in;
	////////////////////////////////////////
	task err(input string m);
		n_mismatch++;
		$display("Error at %0t: %s", $time, m);
	endtask
	task report_and_stop;
		$display("Mismatches %0d of %0d checks", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Expected {enable, level} of one pin; suspend outranks port state
	function automatic logic [1:0] pin_exp(input logic [3:0] s);
		logic [1:0] c;
		c = map_q[2 * (usb_suspended_in ? 3 : chg_port_valid_in ? 1 + chg_port_is_cdp_dcp_in : 0) +: 2];
		case (s)
			4'h1: return 2'h3;
			4'h2: return 2'h2;
			4'h3: return {1'b1, !usb_configured_in || usb_suspended_in};
			4'h4: return {1'b1, !usb_tx_active_in};
			4'h5: return {1'b1, !usb_rx_active_in};
			4'h6: return {1'b1, !(usb_tx_active_in || usb_rx_active_in)};
			4'h7: return {1'b1, !usb_suspended_in};
			4'h8, 4'h9: return {1'b1, c[s - 4'h8]};
			default: return 2'h0;
		endcase
	endfunction
	// Reference one edge behind the inputs, like the design
	always @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			{sel_q, map_q, eo, ed, pa, pu} <= {32'h0, 8'he4, 18'h0};
		end else begin
			for (int i = 0; i < 8; i++)
				{eo[i], ed[i]} <= pin_exp(sel_q[4*i +: 4]);
			sel_q <= cfg_load_in ? cfg_pin_sel_in : sel_q;
			map_q <= cfg_load_in ? cfg_chg_map_in : map_q;
			pa <= '1;
			pu <= pa;
		end
	end
	// Compare settled outputs; cut a hang short
	always @(negedge ref_clk_in) begin
		checked++;
		if (gpio_pin_oe_out !== eo || (gpio_pin_out & eo) !== ed || usb_dplus_pullup_en_out !== pu)
			err("pin drive");
		cyc++;
		if (cyc > 4000) begin
			err("timeout");
			report_and_stop;
		end
	end
	// Corner tables first, then random loads and USB state
	initial begin
		// A real rising edge on reset, so async reset branches fire
		rst_in <= '1;
		repeat (12) @(posedge ref_clk_in);
		rst_in <= '0;
		for (int b = 0; b < 60; b++) begin
			@(posedge ref_clk_in);
			cfg_load_in <= '1;
			cfg_pin_sel_in <= b == 0 ? 32'h9876_5432 : b == 1 ? 32'ha0a1_0bfa : $random(seed);
			cfg_chg_map_in <= b == 0 ? 8'he4 : 8'($random(seed));
			cfg_chg_detect_en_in <= 1'($random(seed));
			vbus <= 1'($random(seed));
			@(posedge ref_clk_in);
			cfg_load_in <= '0;
			repeat (30) begin
				@(posedge ref_clk_in);
				{usb_configured_in, usb_suspended_in, usb_tx_active_in, usb_rx_active_in,
					chg_port_valid_in, chg_port_is_cdp_dcp_in} <= 6'($random(seed));
			end
			ha = '0;
			for (int i = 0; i < 8; i++)
				ha |= sel_q[4*i +: 4] == 4'ha;
			checked++;
			if (vbus_sense_out !== (ha & vbus) || vbus_for_chg_det_out !== (ha & vbus & cfg_chg_detect_en_in))
				err("vbus sense");
			if (b == 30) begin
				rst_in <= '1;
				repeat (3) @(posedge ref_clk_in);
				rst_in <= '0;
			end
		end
		report_and_stop;
	end
endmodule // ugfm_gpio_mux_tb
